// [hdl/epa_pkg.sv]
// constants, field layouts and types for the eight-port serial adapter
// assumes a single system clock; the bit-rate reference arrives as a pin
package epa_pkg;
    localparam int         NUM_CH      = 8;
    localparam int         CH_W        = 3;
    localparam int         FIFO_DEPTH  = 16;
    localparam logic [4:0] FIFO_CAP    = 5'd16;
    localparam logic [4:0] NOFIFO_CAP  = 5'd1;
    localparam logic [11:0] ARB_IO_ADDR = 12'h0130;
    // per-channel register offsets
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IER  = 3'h1;
    localparam logic [2:0] REG_IIR  = 3'h2;
    localparam logic [2:0] REG_LCR  = 3'h3;
    localparam logic [2:0] REG_MCR  = 3'h4;
    localparam logic [2:0] REG_LSR  = 3'h5;
    localparam logic [2:0] REG_MSR  = 3'h6;
    localparam logic [2:0] REG_SCR  = 3'h7;
    localparam int         MCR_POL  = 3;
    localparam logic [7:0] MCR_RST  = 8'h08;
    // interrupt identity codes
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LSR  = 4'h6;
    localparam logic [3:0] IIR_RDA  = 4'h4;
    localparam logic [3:0] IIR_THRE = 4'h2;
    // 16x oversampling tick counts (last tick index)
    localparam logic [5:0] TK_BIT   = 6'd15;
    localparam logic [5:0] TK_HALF  = 6'd7;
    localparam logic [5:0] TK_ST15  = 6'd23;
    localparam logic [5:0] TK_ST2   = 6'd31;
    localparam logic [2:0] WLEN_MAX = 3'd3;
    localparam logic [2:0] BIT_BASE = 3'd4;
    typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} epa_ser_t;
    typedef struct packed {
        logic       dlab;
        logic       brk;
        logic       stick;
        logic       even;
        logic       pen;
        logic       stop2;
        logic [1:0] wlen;
    } epa_lcr_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] zero_hi;
        logic [2:0] adapter;
        logic       zero_lo;
        logic [2:0] port;
        logic [3:0] itype;
    } epa_arb_t;
endpackage

// [hdl/epa_adapter.sv]
// eight-channel start-stop serial adapter with interrupt arbitration
// assumes host strobes are synchronous to clk_sys_in; serial pins and the
// 12.288 MHz reference are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module epa_adapter
    import epa_pkg::*;
#(
    parameter logic [2:0] ADAPTER_ID = 3'h0 // arbitrary default
) (
    // clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              resetn_in,
    // bit-rate reference pin
    input  wire logic              ref_clk_in,
    // channel register access
    input  wire logic [CH_W-1:0]   host_ch_in,
    input  wire logic [2:0]        host_addr_in,
    input  wire logic [7:0]        host_wdata_in,
    input  wire logic              host_wr_in,
    input  wire logic              host_rd_in,
    output logic      [7:0]        host_rdata_out,
    // io space read of arbitration register
    input  wire logic [11:0]       io_addr_in,
    input  wire logic              io_rd_in,
    output logic      [15:0]       io_rdata_out,
    // adapter setup
    input  wire logic              setup_wr_in,
    input  wire logic [2:0]        setup_irq_sel_in,
    // adapter priority chain
    input  wire logic              higher_pend_in,
    output logic                   pend_out,
    // shared request lines, open collector
    output logic      [NUM_CH-1:0] irq_drv_out,
    output logic      [NUM_CH-1:0] irq_oe_out,
    // serial lines
    input  wire logic [NUM_CH-1:0] rx_in,
    output logic      [NUM_CH-1:0] tx_out
);
    logic [2:0]        ref_sync_ff;
    logic [NUM_CH-1:0] rx_s1_ff, rx_s2_ff;
    logic [1:0]        hi_sync_ff;
    logic              ref_rise;
    logic [7:0]        ch_rd [NUM_CH];
    logic [3:0]        ch_iir [NUM_CH];
    logic [NUM_CH-1:0] ch_pend;
    logic [2:0]        irq_sel_ff;
    epa_arb_t          arb_ff, nxt_arb;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ref_sync_ff <= 3'h0;
            rx_s1_ff    <= '1;
            rx_s2_ff    <= '1;
            hi_sync_ff  <= 2'h0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], ref_clk_in};
            rx_s1_ff    <= rx_in;
            rx_s2_ff    <= rx_s1_ff;
            hi_sync_ff  <= {hi_sync_ff[0], higher_pend_in};
        end
    end
    assign ref_rise = ref_sync_ff[1] & ~ref_sync_ff[2];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        epa_lcr_t   lcr_ff;
        logic [7:0] ier_ff, mcr_ff, scr_ff, dll_ff, dlm_ff;
        logic       fifo_en_ff, thre_pend_ff;
        logic [3:0] err_ff, err_set;
        logic [7:0] txq [FIFO_DEPTH];
        logic [7:0] rxq [FIFO_DEPTH];
        logic [3:0] tx_rp_ff, tx_wp_ff, rx_rp_ff, rx_wp_ff;
        logic [4:0] tx_cnt_ff, rx_cnt_ff, cap;
        logic [15:0] div_ff, div_m1;
        logic       tick, wr_sel, rd_sel, tx_push, tx_pop, rx_pop, rx_push;
        logic       pol, rx_lvl, fcr_wr;
        epa_ser_t   tx_st_ff, rx_st_ff;
        logic [5:0] tx_tk_ff, rx_tk_ff, stop_last;
        logic [2:0] tx_bit_ff, rx_bit_ff, last_bit;
        logic [7:0] tx_sh_ff, rx_sh_ff;
        logic       tx_par_ff, rx_par_ff, tx_line_ff, tx_pin_ff, rx_zero_ff;

        assign wr_sel   = host_wr_in && (host_ch_in == CH_W'(i));
        assign rd_sel   = host_rd_in && (host_ch_in == CH_W'(i));
        assign cap      = fifo_en_ff ? FIFO_CAP : NOFIFO_CAP;
        assign tx_push  = wr_sel && host_addr_in == REG_DATA && !lcr_ff.dlab
                          && tx_cnt_ff < cap;
        assign rx_pop   = rd_sel && host_addr_in == REG_DATA && !lcr_ff.dlab
                          && rx_cnt_ff != 5'd0;
        assign fcr_wr   = wr_sel && host_addr_in == REG_IIR;
        assign tx_pop   = tx_st_ff == SER_IDLE && tx_cnt_ff != 5'd0;
        // index of the last data bit
        assign last_bit = BIT_BASE + {1'b0, lcr_ff.wlen};
        assign pol      = mcr_ff[MCR_POL];
        assign rx_lvl   = rx_s2_ff[i] ^ ~pol;
        assign stop_last = !lcr_ff.stop2 ? TK_BIT :
                           (lcr_ff.wlen == 2'd0) ? TK_ST15 : TK_ST2;

        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
                lcr_ff     <= '0;
                ier_ff     <= 8'h00;
                mcr_ff     <= MCR_RST;
                scr_ff     <= 8'h00;
                dll_ff     <= 8'h00;
                dlm_ff     <= 8'h00;
                fifo_en_ff <= 1'b0;
            end else if (wr_sel) begin
                case (host_addr_in)
                    REG_DATA: if (lcr_ff.dlab) dll_ff <= host_wdata_in;
                    REG_IER:  if (lcr_ff.dlab) dlm_ff <= host_wdata_in;
                              else ier_ff <= host_wdata_in;
                    REG_IIR:  fifo_en_ff <= host_wdata_in[0];
                    REG_LCR:  lcr_ff <= epa_lcr_t'(host_wdata_in);
                    REG_MCR:  mcr_ff <= host_wdata_in;
                    REG_SCR:  scr_ff <= host_wdata_in;
                    default:  ;
                endcase
            end
        end

        assign div_m1 = ({dlm_ff, dll_ff} == 16'h0000) ? 16'h0000
                        : {dlm_ff, dll_ff} - 16'h0001;
        assign tick   = ref_rise && div_ff >= div_m1;
        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) div_ff <= 16'h0000;
            else if (tick) div_ff <= 16'h0000;
            else if (ref_rise) div_ff <= div_ff + 16'h0001;
        end

        always_ff @(posedge clk_sys_in) begin
            if (tx_push) txq[tx_wp_ff] <= host_wdata_in;
            if (rx_push) rxq[rx_wp_ff] <= rx_sh_ff >> (WLEN_MAX - {1'b0, lcr_ff.wlen});
        end
        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
                tx_rp_ff <= 4'h0;
                tx_wp_ff <= 4'h0;
                tx_cnt_ff <= 5'd0;
            end else if (fcr_wr && host_wdata_in[2]) begin
                tx_rp_ff <= 4'h0;
                tx_wp_ff <= 4'h0;
                tx_cnt_ff <= 5'd0;
            end else begin
                tx_wp_ff  <= tx_wp_ff + {3'h0, tx_push};
                tx_rp_ff  <= tx_rp_ff + {3'h0, tx_pop};
                tx_cnt_ff <= tx_cnt_ff + {4'h0, tx_push} - {4'h0, tx_pop};
            end
        end

        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
                tx_st_ff   <= SER_IDLE;
                tx_tk_ff   <= 6'd0;
                tx_bit_ff  <= 3'd0;
                tx_sh_ff   <= 8'h00;
                tx_par_ff  <= 1'b0;
                tx_line_ff <= 1'b1;
            end else if (tx_pop) begin
                tx_st_ff   <= SER_START;
                tx_sh_ff   <= txq[tx_rp_ff];
                tx_tk_ff   <= 6'd0;
                tx_par_ff  <= ~lcr_ff.even;
                tx_line_ff <= 1'b0;
            end else if (tick && tx_st_ff != SER_IDLE) begin
                tx_tk_ff <= tx_tk_ff + 6'd1;
                case (tx_st_ff)
                    SER_START: if (tx_tk_ff == TK_BIT) begin
                        tx_st_ff   <= SER_DATA;
                        tx_tk_ff   <= 6'd0;
                        tx_bit_ff  <= 3'd0;
                        tx_line_ff <= tx_sh_ff[0];
                        tx_par_ff  <= tx_par_ff ^ tx_sh_ff[0];
                    end
                    SER_DATA: if (tx_tk_ff == TK_BIT) begin
                        tx_tk_ff <= 6'd0;
                        if (tx_bit_ff == last_bit) begin
                            tx_st_ff   <= lcr_ff.pen ? SER_PAR : SER_STOP;
                            tx_line_ff <= lcr_ff.pen ? tx_par_ff : 1'b1;
                        end else begin
                            tx_bit_ff  <= tx_bit_ff + 3'd1;
                            tx_sh_ff   <= tx_sh_ff >> 1;
                            tx_line_ff <= tx_sh_ff[1];
                            tx_par_ff  <= tx_par_ff ^ tx_sh_ff[1];
                        end
                    end
                    SER_PAR: if (tx_tk_ff == TK_BIT) begin
                        tx_st_ff   <= SER_STOP;
                        tx_tk_ff   <= 6'd0;
                        tx_line_ff <= 1'b1;
                    end
                    SER_STOP: if (tx_tk_ff == stop_last) tx_st_ff <= SER_IDLE;
                    default: tx_st_ff <= SER_IDLE;
                endcase
            end
        end

        // break and polarity at the pin
        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) tx_pin_ff <= 1'b1;
            else tx_pin_ff <= (tx_line_ff & ~lcr_ff.brk) ^ ~pol;
        end
        assign tx_out[i] = tx_pin_ff;

        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
                rx_st_ff   <= SER_IDLE;
                rx_tk_ff   <= 6'd0;
                rx_bit_ff  <= 3'd0;
                rx_sh_ff   <= 8'h00;
                rx_par_ff  <= 1'b0;
                rx_zero_ff <= 1'b1;
            end else if (tick) begin
                rx_tk_ff <= rx_tk_ff + 6'd1;
                case (rx_st_ff)
                    SER_IDLE: if (!rx_lvl) begin
                        rx_st_ff <= SER_START;
                        rx_tk_ff <= 6'd0;
                    end
                    SER_START: if (rx_tk_ff == TK_HALF) begin
                        rx_st_ff   <= rx_lvl ? SER_IDLE : SER_DATA;
                        rx_tk_ff   <= 6'd0;
                        rx_bit_ff  <= 3'd0;
                        rx_par_ff  <= 1'b0;
                        rx_zero_ff <= 1'b1;
                    end
                    SER_DATA: if (rx_tk_ff == TK_BIT) begin
                        rx_tk_ff   <= 6'd0;
                        rx_sh_ff   <= {rx_lvl, rx_sh_ff[7:1]};
                        rx_par_ff  <= rx_par_ff ^ rx_lvl;
                        rx_zero_ff <= rx_zero_ff & ~rx_lvl;
                        rx_bit_ff  <= rx_bit_ff + 3'd1;
                        if (rx_bit_ff == last_bit)
                            rx_st_ff <= lcr_ff.pen ? SER_PAR : SER_STOP;
                    end
                    SER_PAR: if (rx_tk_ff == TK_BIT) begin
                        rx_tk_ff   <= 6'd0;
                        rx_par_ff  <= rx_par_ff ^ rx_lvl;
                        rx_zero_ff <= rx_zero_ff & ~rx_lvl;
                        rx_st_ff   <= SER_STOP;
                    end
                    SER_STOP: if (rx_tk_ff == TK_BIT) rx_st_ff <= SER_IDLE;
                    default: rx_st_ff <= SER_IDLE;
                endcase
            end
        end
        assign rx_push = tick && rx_st_ff == SER_STOP && rx_tk_ff == TK_BIT
                         && rx_cnt_ff < cap;

        // line status events: overrun, parity, framing, break
        always_comb begin
            err_set = 4'h0;
            if (tick && rx_st_ff == SER_STOP && rx_tk_ff == TK_BIT) begin
                err_set[0] = rx_cnt_ff >= cap;
                err_set[1] = lcr_ff.pen && (rx_par_ff ^ ~lcr_ff.even);
                err_set[2] = !rx_lvl;
                err_set[3] = rx_zero_ff && !rx_lvl;
            end
        end
        // set wins over the read that clears
        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) err_ff <= 4'h0;
            else if (rd_sel && host_addr_in == REG_LSR) err_ff <= err_set;
            else err_ff <= err_ff | err_set;
        end

        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
                rx_rp_ff <= 4'h0;
                rx_wp_ff <= 4'h0;
                rx_cnt_ff <= 5'd0;
            end else if (fcr_wr && host_wdata_in[1]) begin
                rx_rp_ff <= 4'h0;
                rx_wp_ff <= 4'h0;
                rx_cnt_ff <= 5'd0;
            end else begin
                rx_wp_ff  <= rx_wp_ff + {3'h0, rx_push};
                rx_rp_ff  <= rx_rp_ff + {3'h0, rx_pop};
                rx_cnt_ff <= rx_cnt_ff + {4'h0, rx_push} - {4'h0, rx_pop};
            end
        end

        // transmit-empty event, set wins over clear
        always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) thre_pend_ff <= 1'b0;
            else if (tx_pop && tx_cnt_ff == 5'd1 && !tx_push) thre_pend_ff <= 1'b1;
            else if (tx_push || (rd_sel && host_addr_in == REG_IIR
                     && ch_iir[i] == IIR_THRE)) thre_pend_ff <= 1'b0;
        end

        always_comb begin
            if (ier_ff[2] && err_ff != 4'h0) ch_iir[i] = IIR_LSR;
            else if (ier_ff[0] && rx_cnt_ff != 5'd0) ch_iir[i] = IIR_RDA;
            else if (ier_ff[1] && thre_pend_ff) ch_iir[i] = IIR_THRE;
            else ch_iir[i] = IIR_NONE;
        end
        assign ch_pend[i] = ch_iir[i] != IIR_NONE;

        always_comb begin
            case (host_addr_in)
                REG_DATA: ch_rd[i] = lcr_ff.dlab ? dll_ff : rxq[rx_rp_ff];
                REG_IER:  ch_rd[i] = lcr_ff.dlab ? dlm_ff : ier_ff;
                REG_IIR:  ch_rd[i] = {{2{fifo_en_ff}}, 2'b00, ch_iir[i]};
                REG_LCR:  ch_rd[i] = lcr_ff;
                REG_MCR:  ch_rd[i] = mcr_ff;
                REG_LSR:  ch_rd[i] = {1'b0, tx_cnt_ff == 5'd0 && tx_st_ff == SER_IDLE,
                                      tx_cnt_ff == 5'd0, err_ff[3:0],
                                      rx_cnt_ff != 5'd0};
                REG_MSR:  ch_rd[i] = 8'h00;
                default:  ch_rd[i] = scr_ff;
            endcase
        end

        property p_fifo_cap;
            @(posedge clk_sys_in) disable iff (!resetn_in)
            ##1 (tx_cnt_ff <= FIFO_CAP && rx_cnt_ff <= FIFO_CAP);
        endproperty
        a_fifo_cap: assert property (p_fifo_cap)
            else $error("queue count above capacity");
        property p_start_space;
            @(posedge clk_sys_in) disable iff (!resetn_in)
            $rose(tx_st_ff == SER_START) |-> !tx_line_ff ##1 tx_pin_ff == ~pol;
        endproperty
        a_start_space: assert property (p_start_space)
            else $error("start bit not space");
        property p_stop_one;
            @(posedge clk_sys_in) disable iff (!resetn_in)
            (tx_st_ff == SER_STOP && !lcr_ff.stop2) |-> tx_tk_ff <= TK_BIT && tx_line_ff;
        endproperty
        a_stop_one: assert property (p_stop_one)
            else $error("single stop period overrun");
        property p_par_gate;
            @(posedge clk_sys_in) disable iff (!resetn_in)
            $rose(err_ff[1]) |-> $past(lcr_ff.pen);
        endproperty
        a_par_gate: assert property (p_par_gate)
            else $error("parity error without parity enabled");
    end

    // fixed port priority, yielding to higher adapters
    always_comb begin
        nxt_arb       = '0;
        nxt_arb.itype = IIR_NONE;
        nxt_arb.adapter = ADAPTER_ID;
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (ch_pend[k] && !hi_sync_ff[1]) begin
                nxt_arb.valid = 1'b1;
                nxt_arb.port  = CH_W'(k);
                nxt_arb.itype = ch_iir[k];
            end
        end
    end

    // arbitration register, io read, line select
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            arb_ff         <= '0;
            io_rdata_out   <= 16'h0000;
            host_rdata_out <= 8'h00;
            irq_sel_ff     <= 3'h0;
            pend_out       <= 1'b0;
        end else begin
            arb_ff         <= nxt_arb;
            pend_out       <= |ch_pend;
            io_rdata_out   <= (io_rd_in && io_addr_in == ARB_IO_ADDR) ? arb_ff : 16'h0000;
            if (host_rd_in) host_rdata_out <= ch_rd[host_ch_in];
            if (setup_wr_in) irq_sel_ff <= setup_irq_sel_in;
        end
    end

    // open-collector request, released when nothing pends
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_oe_out  <= '0;
            irq_drv_out <= '0;
        end else begin
            irq_drv_out <= '0;
            for (int k = 0; k < NUM_CH; k++)
                irq_oe_out[k] <= (|ch_pend) && irq_sel_ff == CH_W'(k);
        end
    end

    sequence s_arb_read;
        io_rd_in && io_addr_in == ARB_IO_ADDR;
    endsequence
    property p_arb_read;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        s_arb_read |=> io_rdata_out == $past(arb_ff);
    endproperty
    a_arb_read: assert property (p_arb_read)
        else $error("arbitration read data wrong");
    property p_port0_first;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (ch_pend[0] && !hi_sync_ff[1]) |=> arb_ff.valid && arb_ff.port == 3'h0;
    endproperty
    a_port0_first: assert property (p_port0_first)
        else $error("port 0 not selected first");
    property p_one_line;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        $onehot0(irq_oe_out) && irq_drv_out == '0;
    endproperty
    a_one_line: assert property (p_one_line)
        else $error("more than one request line driven");
    property p_release;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (ch_pend == '0) |=> irq_oe_out == '0;
    endproperty
    a_release: assert property (p_release)
        else $error("request held with nothing pending");
    property p_yield;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        hi_sync_ff[1] |=> !arb_ff.valid;
    endproperty
    a_yield: assert property (p_yield)
        else $error("arbitration did not yield");
endmodule // epa_adapter
`default_nettype wire

// [tb/epa_term.sv]
// serial terminal model: echoes each 8-bit no-parity character whose start edge comes while it is not echoing
// assumes normal polarity and a bit time of 16 reference periods
`timescale 1ns/1ps
`default_nettype none
module epa_term #(
    parameter realtime BIT_NS = 1302.08
) (
    input  wire logic tx_in,
    output logic      rx_out
);
    logic [7:0] char_q;
    initial rx_out = 1'b1;
    always begin
        @(negedge tx_in);
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++) begin
            char_q[i] = tx_in;
            #(BIT_NS);
        end
        rx_out = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            rx_out = char_q[i];
            #(BIT_NS);
        end
        rx_out = 1'b1;
        #(BIT_NS);
    end
endmodule // epa_term
`default_nettype wire

// [tb/epa_adapter_bench.sv]
// self-checking bench for the eight-port serial adapter
// assumes the terminal model on port 0; other receive lines idle at mark
`timescale 1ns/1ps
`default_nettype none
module epa_adapter_bench
    import epa_pkg::*;
;
    localparam logic [2:0] AID = 3'h5; // arbitrary adapter number
    logic clk = 0, rstn = 0, refc = 0, wr = 0, rd = 0, io_rd = 0, sw = 0, hp = 0, pend, trx;
    logic [2:0] ch = 0, ad = 0, sel = 0;
    logic [7:0] wd = 0, rdat, drv, oe, tx;
    logic [11:0] ioa = 0;
    logic [15:0] iod, got;
    int err_count = 0, checked = 0;
    logic [14:0] rows [9] = '{{1'b0, 3'd0, REG_MCR, 8'h08}, {1'b0, 3'd5, REG_LSR, 8'h60},
        {1'b0, 3'd7, REG_IIR, 8'h01}, {1'b1, 3'd3, REG_SCR, 8'h5a}, {1'b0, 3'd3, REG_SCR, 8'h5a},
        {1'b1, 3'd6, REG_SCR, 8'hc3}, {1'b0, 3'd6, REG_SCR, 8'hc3}, {1'b0, 3'd3, REG_SCR, 8'h5a},
        {1'b0, 3'd2, REG_MSR, 8'h00}};
    always #5 clk = ~clk;
    always #40.69 refc = ~refc;
    epa_adapter #(.ADAPTER_ID(AID)) epa_adapter_i (.clk_sys_in(clk), .resetn_in(rstn),
        .ref_clk_in(refc),
        .host_ch_in(ch), .host_addr_in(ad), .host_wdata_in(wd), .host_wr_in(wr),
        .host_rd_in(rd), .host_rdata_out(rdat), .io_addr_in(ioa), .io_rd_in(io_rd),
        .io_rdata_out(iod), .setup_wr_in(sw), .setup_irq_sel_in(sel), .higher_pend_in(hp),
        .pend_out(pend), .irq_drv_out(drv), .irq_oe_out(oe), .rx_in({7'h7f, trx}), .tx_out(tx));
    epa_term epa_term_i (.tx_in(tx[0]), .rx_out(trx));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [2:0] c, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk) {ch, ad, wd, wr} = {c, a, d, 1'b1};
        @(negedge clk) wr = 0;
    endtask
    task automatic rreg(input logic [2:0] c, input logic [2:0] a, output logic [15:0] g);
        @(negedge clk) {ch, ad, rd} = {c, a, 1'b1};
        @(negedge clk) rd = 0;
        @(negedge clk) g = {8'h00, rdat};
    endtask
    task automatic rio(input logic [11:0] a, output logic [15:0] g);
        @(negedge clk) {ioa, io_rd} = {a, 1'b1};
        // the word stands for one cycle only
        @(negedge clk) begin
            g = iod;
            io_rd = 0;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200_000 err_count++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        foreach (rows[i]) begin
            if (rows[i][14]) wreg(rows[i][13:11], rows[i][10:8], rows[i][7:0]);
            else begin
                rreg(rows[i][13:11], rows[i][10:8], got);
                chk(got, {8'h00, rows[i][7:0]});
            end
        end
        rio(12'h0131, got);
        chk(got, 16'h0000);
        rio(ARB_IO_ADDR, got);
        chk(got, {1'b0, 4'h0, AID, 1'b0, 3'h0, IIR_NONE});
        $display("register table done");
        @(negedge clk) {sel, sw} = {3'd3, 1'b1};
        @(negedge clk) sw = 0;
        wreg(0, REG_LCR, 8'h80);
        wreg(0, REG_DATA, 8'h01);
        wreg(0, REG_IER, 8'h00);
        wreg(0, REG_LCR, 8'h03);
        wreg(0, REG_IER, 8'h01);
        wreg(0, REG_DATA, 8'ha5);
        for (int n = 0; n < 6000 && pend !== 1'b1; n++) @(negedge clk);
        chk({drv, oe}, 16'h0008);
        rio(ARB_IO_ADDR, got);
        chk(got, {1'b1, 4'h0, AID, 1'b0, 3'h0, IIR_RDA});
        @(negedge clk) hp = 1;
        repeat (4) @(negedge clk);
        rio(ARB_IO_ADDR, got);
        chk(got, {1'b0, 4'h0, AID, 1'b0, 3'h0, IIR_NONE});
        chk({8'h00, oe}, 16'h0008);
        @(negedge clk) hp = 0;
        repeat (4) @(negedge clk);
        rreg(0, REG_DATA, got);
        chk(got, 16'h00a5);
        repeat (3) @(negedge clk);
        chk({7'h00, pend, oe}, 16'h0000);
        $display("echo and request done");
        wreg(1, REG_MCR, 8'h00);
        repeat (2) @(negedge clk);
        chk({8'h00, tx}, 16'h00fd);
        @(negedge clk) rstn = 0;
        @(negedge clk) chk({8'h00, tx}, 16'h00ff);
        chk({7'h00, pend, oe}, 16'h0000);
        @(negedge clk) rstn = 1;
        rreg(1, REG_MCR, got);
        chk(got, 16'h0008);
        rio(ARB_IO_ADDR, got);
        chk(got, {1'b0, 4'h0, AID, 1'b0, 3'h0, IIR_NONE});
        $display("polarity and reset done");
        conclude();
    end
endmodule // epa_adapter_bench
`default_nettype wire
